// *** ertr_defines.svh ***
/*
 * Constants of the error-list and time read-out block exchange: block codes,
 * word positions, limits, reset values and timing counts.
 * Assumes a single 10 MHz clock and 16-bit backplane block words.
 */
`ifndef ERTR_DEFINES_SVH
`define ERTR_DEFINES_SVH

// Block identification codes (9950 and 9970).
`define ERTR_ID_ERR_LIST     16'h26DE
`define ERTR_ID_TIME         16'h26F2

// Command table size and request limits.
`define ERTR_MAX_CMD         16'h03E8
`define ERTR_MAX_REQ_COUNT   16'h00C8
`define ERTR_MIN_REQ_COUNT   16'h0001

// Word positions in request and response blocks.
`define ERTR_REQ_LAST_WORD   8'hF7
`define ERTR_W_REQ_COUNT     8'h01
`define ERTR_W_REQ_START     8'h02
`define ERTR_RSP_LAST_WORD   8'hF9
`define ERTR_RSP_END         8'hFA
`define ERTR_W_RESERVED      8'h00
`define ERTR_W_NEXT_ID       8'h01
`define ERTR_W_COUNT         8'h02
`define ERTR_W_START         8'h03
`define ERTR_W_FIRST_ERR     8'h04
`define ERTR_W_YEAR          8'h02
`define ERTR_W_MONTH         8'h03
`define ERTR_W_DAY           8'h04
`define ERTR_W_HOUR          8'h05
`define ERTR_W_MINUTE        8'h06
`define ERTR_W_SECOND        8'h07
`define ERTR_W_MSEC          8'h08

// Timing: one millisecond at a 100 ns clock period.
`define ERTR_MS_NS           32'h000F4240
`define ERTR_CLK_PERIOD_NS   32'h00000064
`define ERTR_CYCLES_PER_MS   ((`ERTR_MS_NS + `ERTR_CLK_PERIOD_NS - 32'h1) / `ERTR_CLK_PERIOD_NS)

// Calendar limits and reset time (arbitrary start date).
`define ERTR_RST_YEAR        16'h07D0
`define ERTR_MS_MAX          10'h3E7
`define ERTR_SEC_MAX         6'h3B
`define ERTR_HOUR_MAX        5'h17
`define ERTR_MONTH_MAX       4'hC

`endif

// *** ertr_pkg.sv ***
/*
 * Types shared by the error-list and time read-out block exchange.
 * Assumes ertr_defines.svh is compiled with it.
 */
package ertr_pkg;

	// Calendar time as kept by the module clock.
	typedef struct packed {
		logic [15:0] year;
		logic [3:0]  month;
		logic [4:0]  day;
		logic [4:0]  hour;
		logic [5:0]  minute;
		logic [5:0]  second;
		logic [9:0]  msec;
	} ertr_time_t;

	typedef enum logic [1:0] {
		ERTR_ST_IDLE,
		ERTR_ST_RECV,
		ERTR_ST_SEND
	} ertr_state_t;

	typedef enum logic [1:0] {
		ERTR_K_NONE,
		ERTR_K_ERR,
		ERTR_K_TIME
	} ertr_kind_t;

	// One backplane word with its framing marks.
	typedef struct packed {
		logic        valid;
		logic        first;
		logic        last;
		logic [15:0] data;
	} ertr_word_t;

endpackage : ertr_pkg

// *** ertr_time_keeper.sv ***
/*
 * Module date and time counter, advanced once per millisecond.
 * Assumes one clock; a load from the same clock domain overrides counting.
 */
`timescale 1ns/1ps
`include "ertr_defines.svh"

module ertr_time_keeper #(
	parameter int unsigned CYCLES_PER_MS = `ERTR_CYCLES_PER_MS
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               loadEn,
	input  wire ertr_pkg::ertr_time_t loadValue,
	output      ertr_pkg::ertr_time_t now
);

	typedef struct packed {
		logic [15:0]          tick;
		ertr_pkg::ertr_time_t t;
	} ertr_tk_state_t;

	ertr_tk_state_t st_reg;
	ertr_tk_state_t st_next;

	// Days in a month, leap years by the four-year rule only (good to 2099).
	function automatic logic [4:0] daysIn(input logic [3:0] m, input logic [15:0] y);
		logic [4:0] d;
		d = 5'h1F;
		case (m)
			4'h4, 4'h6, 4'h9, 4'hB: d = 5'h1E;
			4'h2: d = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
			default: d = 5'h1F;
		endcase
		return d;
	endfunction : daysIn

	// Ripple the carry from milliseconds up to the year.
	always_comb begin
		st_next = st_reg;
		if (loadEn) begin
			st_next.t = loadValue;
			st_next.tick = 16'h0000;
		end else if (st_reg.tick == 16'(CYCLES_PER_MS - 1)) begin
			st_next.tick = 16'h0000;
			st_next.t.msec = st_reg.t.msec + 10'h001;
			if (st_reg.t.msec == `ERTR_MS_MAX) begin
				st_next.t.msec = 10'h000;
				st_next.t.second = st_reg.t.second + 6'h01;
				if (st_reg.t.second == `ERTR_SEC_MAX) begin
					st_next.t.second = 6'h00;
					st_next.t.minute = st_reg.t.minute + 6'h01;
					if (st_reg.t.minute == `ERTR_SEC_MAX) begin
						st_next.t.minute = 6'h00;
						st_next.t.hour = st_reg.t.hour + 5'h01;
						if (st_reg.t.hour == `ERTR_HOUR_MAX) begin
							st_next.t.hour = 5'h00;
							st_next.t.day = st_reg.t.day + 5'h01;
							if (st_reg.t.day >= daysIn(st_reg.t.month, st_reg.t.year)) begin
								st_next.t.day = 5'h01;
								st_next.t.month = st_reg.t.month + 4'h1;
								if (st_reg.t.month >= `ERTR_MONTH_MAX) begin
									st_next.t.month = 4'h1;
									st_next.t.year = st_reg.t.year + 16'h0001;
								end
							end
						end
					end
				end
			end
		end else begin
			st_next.tick = st_reg.tick + 16'h0001;
		end
	end

	// Reset starts the calendar at an arbitrary first of January.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '{tick: 16'h0000, t: '{year: `ERTR_RST_YEAR, month: 4'h1, day: 5'h01,
				hour: 5'h00, minute: 6'h00, second: 6'h00, msec: 10'h000}};
		end else begin
			st_reg <= st_next;
		end
	end

	assign now = st_reg.t;

endmodule : ertr_time_keeper

// *** ertr_block_xchg.sv ***
/*
 * Block exchange for the command error list and the time read-out.
 * Request words arrive one per accepted cycle from same-clock backplane logic;
 * response words leave with valid/ready handshake. Error codes are written by
 * the command engine on the same clock.
 */
`timescale 1ns/1ps
`include "ertr_defines.svh"

module ertr_block_xchg #(
	parameter int unsigned CYCLES_PER_MS = `ERTR_CYCLES_PER_MS
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 reqValid,
	input  wire logic                 reqFirst,
	input  wire logic [15:0]          reqData,
	output      logic                 reqReady,
	input  wire logic                 rspReady,
	output      logic                 rspValid,
	output      logic                 rspFirst,
	output      logic                 rspLast,
	output      logic [15:0]          rspData,
	input  wire logic                 errWrEn,
	input  wire logic [9:0]           errWrIndex,
	input  wire logic [15:0]          errWrCode,
	input  wire logic [15:0]          nextBlockId,
	input  wire logic                 timeLoadEn,
	input  wire ertr_pkg::ertr_time_t timeLoadValue
);

	typedef struct packed {
		ertr_pkg::ertr_state_t state;
		ertr_pkg::ertr_kind_t  kind;
		logic                  reqReady;
		logic [7:0]            reqIdx;
		logic [15:0]           reqCount;
		logic [15:0]           reqStart;
		logic [7:0]            rspIdx;
		logic [7:0]            rspCount;
		logic [9:0]            rspBase;
		logic [15:0]           nextId;
		ertr_pkg::ertr_time_t  snap;
		ertr_pkg::ertr_word_t  out;
	} ertr_xchg_state_t;

	ertr_xchg_state_t     st_reg;
	ertr_xchg_state_t     st_next;
	ertr_pkg::ertr_time_t timeNow;
	logic [15:0]          errTable [0:999];
	logic [9:0]           rdIndex;
	logic [15:0]          wordVal;
	logic [15:0]          limitCount;
	logic                 reqTake;
	logic                 reqDone;
	logic                 reqOk;
	logic                 canLoad;

	// Running date and time that the time response reports.
	ertr_time_keeper #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) timeKeeper (
		.clk       (clk),
		.rst_n     (rst_n),
		.loadEn    (timeLoadEn),
		.loadValue (timeLoadValue),
		.now       (timeNow)
	);

	// Last-error table, one entry per configurable command; no reset, so
	// entries read as whatever was last written.
	always_ff @(posedge clk) begin
		if (errWrEn && ({6'h00, errWrIndex} < `ERTR_MAX_CMD)) begin
			errTable[errWrIndex] <= errWrCode;
		end
	end

	assign reqTake = reqValid && st_reg.reqReady;
	assign reqDone = reqTake && (st_reg.state == ertr_pkg::ERTR_ST_RECV)
		&& (st_reg.reqIdx == `ERTR_REQ_LAST_WORD);
	assign canLoad = !st_reg.out.valid || rspReady;

	// Entries left from the start index to the end of the table; a window
	// that runs past the end is cut short rather than refused.
	assign limitCount = 16'(`ERTR_MAX_CMD - st_reg.reqStart);

	// Validity of a completed request: known code; for the error list, count and start in range.
	always_comb begin
		reqOk = 1'b0;
		if (st_reg.kind == ertr_pkg::ERTR_K_TIME) begin
			reqOk = 1'b1;
		end else if (st_reg.kind == ertr_pkg::ERTR_K_ERR) begin
			reqOk = (st_reg.reqCount >= `ERTR_MIN_REQ_COUNT)
				&& (st_reg.reqCount <= `ERTR_MAX_REQ_COUNT)
				&& (st_reg.reqStart < `ERTR_MAX_CMD);
		end
	end

	assign rdIndex = 10'(st_reg.rspBase + {2'h0, st_reg.rspIdx} - {2'h0, `ERTR_W_FIRST_ERR});

	// Content of response word rspIdx for the block being sent.
	always_comb begin
		wordVal = 16'h0000; // Reserved and spare words read as zero.
		if (st_reg.rspIdx == `ERTR_W_NEXT_ID) begin
			wordVal = st_reg.nextId;
		end else if (st_reg.kind == ertr_pkg::ERTR_K_ERR) begin
			if (st_reg.rspIdx == `ERTR_W_COUNT) begin
				wordVal = {8'h00, st_reg.rspCount};
			end else if (st_reg.rspIdx == `ERTR_W_START) begin
				wordVal = {6'h00, st_reg.rspBase};
			end else if (st_reg.rspIdx >= `ERTR_W_FIRST_ERR
				&& st_reg.rspIdx < 8'(`ERTR_W_FIRST_ERR + st_reg.rspCount)) begin
				wordVal = errTable[rdIndex];
			end else if (st_reg.rspIdx == `ERTR_RSP_LAST_WORD) begin
				wordVal = `ERTR_ID_ERR_LIST;
			end
		end else begin
			case (st_reg.rspIdx)
				`ERTR_W_YEAR:   wordVal = st_reg.snap.year;
				`ERTR_W_MONTH:  wordVal = {12'h000, st_reg.snap.month};
				`ERTR_W_DAY:    wordVal = {11'h000, st_reg.snap.day};
				`ERTR_W_HOUR:   wordVal = {11'h000, st_reg.snap.hour};
				`ERTR_W_MINUTE: wordVal = {10'h000, st_reg.snap.minute};
				`ERTR_W_SECOND: wordVal = {10'h000, st_reg.snap.second};
				`ERTR_W_MSEC:   wordVal = {6'h00, st_reg.snap.msec};
				`ERTR_RSP_LAST_WORD: wordVal = `ERTR_ID_TIME;
				default:        wordVal = 16'h0000;
			endcase
		end
	end

	// Request capture, validation and response sequencing.
	always_comb begin
		st_next = st_reg;
		if (st_reg.out.valid && rspReady) begin
			st_next.out.valid = 1'b0;
		end
		case (st_reg.state)
			ertr_pkg::ERTR_ST_IDLE, ertr_pkg::ERTR_ST_RECV: begin
				// A first word always restarts capture, so a torn block cannot lock us up.
				if (reqTake && reqFirst) begin
					st_next.state = ertr_pkg::ERTR_ST_RECV;
					st_next.reqIdx = 8'h01;
					if (reqData == `ERTR_ID_ERR_LIST) begin
						st_next.kind = ertr_pkg::ERTR_K_ERR;
					end else if (reqData == `ERTR_ID_TIME) begin
						st_next.kind = ertr_pkg::ERTR_K_TIME;
					end else begin
						st_next.kind = ertr_pkg::ERTR_K_NONE;
					end
				end else if (reqTake && st_reg.state == ertr_pkg::ERTR_ST_RECV) begin
					st_next.reqIdx = st_reg.reqIdx + 8'h01;
					if (st_reg.reqIdx == `ERTR_W_REQ_COUNT) begin
						st_next.reqCount = reqData;
					end
					if (st_reg.reqIdx == `ERTR_W_REQ_START) begin
						st_next.reqStart = reqData;
					end
					if (reqDone) begin
						// Invalid or unknown blocks are dropped without an answer.
						st_next.state = reqOk ? ertr_pkg::ERTR_ST_SEND
							: ertr_pkg::ERTR_ST_IDLE;
						st_next.reqReady = !reqOk;
						st_next.rspIdx = 8'h00;
						st_next.rspBase = st_reg.reqStart[9:0];
						st_next.rspCount = (st_reg.reqCount > limitCount) ? limitCount[7:0]
							: st_reg.reqCount[7:0];
						st_next.nextId = nextBlockId;
						st_next.snap = timeNow; // One snapshot keeps the block consistent.
					end
				end
			end
			ertr_pkg::ERTR_ST_SEND: begin
				if (canLoad) begin
					if (st_reg.rspIdx == `ERTR_RSP_END) begin
						st_next.state = ertr_pkg::ERTR_ST_IDLE;
						st_next.reqReady = 1'b1;
					end else begin
						st_next.out.valid = 1'b1;
						st_next.out.first = (st_reg.rspIdx == `ERTR_W_RESERVED);
						st_next.out.last = (st_reg.rspIdx == `ERTR_RSP_LAST_WORD);
						st_next.out.data = wordVal;
						st_next.rspIdx = st_reg.rspIdx + 8'h01;
					end
				end
			end
			default: begin
				st_next.state = ertr_pkg::ERTR_ST_IDLE;
			end
		endcase
	end

	// Single state register; request side is ready straight after reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.state <= ertr_pkg::ERTR_ST_IDLE;
			st_reg.kind <= ertr_pkg::ERTR_K_NONE;
			st_reg.reqReady <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reqReady = st_reg.reqReady;
	assign rspValid = st_reg.out.valid;
	assign rspFirst = st_reg.out.first;
	assign rspLast = st_reg.out.last;
	assign rspData = st_reg.out.data;

	// Index of the word now on the response port.
	logic [7:0] outIdx;
	assign outIdx = st_reg.rspIdx - 8'h01;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	table_write_a: assert property (
		errWrEn && ({6'h00, errWrIndex} < `ERTR_MAX_CMD)
		|=> errTable[$past(errWrIndex)] == $past(errWrCode))
		else $error("Error table entry not updated.");

	reserved_zero_a: assert property (
		rspValid && rspFirst |-> rspData == 16'h0000 && outIdx == 8'h00)
		else $error("Response word 0 is not zero.");

	next_id_word_a: assert property (
		rspValid && outIdx == `ERTR_W_NEXT_ID |-> rspData == st_reg.nextId)
		else $error("Next block code missing from word 1.");

	count_range_a: assert property (
		rspValid && st_reg.kind == ertr_pkg::ERTR_K_ERR && outIdx == `ERTR_W_COUNT
		|-> rspData >= `ERTR_MIN_REQ_COUNT && rspData <= `ERTR_MAX_REQ_COUNT)
		else $error("Reported count out of range.");

	start_range_a: assert property (
		rspValid && st_reg.kind == ertr_pkg::ERTR_K_ERR && outIdx == `ERTR_W_START
		|-> rspData < `ERTR_MAX_CMD)
		else $error("Reported start index out of range.");

	spare_err_a: assert property (
		rspValid && st_reg.kind == ertr_pkg::ERTR_K_ERR
		&& outIdx >= 8'(`ERTR_W_FIRST_ERR + st_reg.rspCount) && !rspLast
		|-> rspData == 16'h0000)
		else $error("Word beyond the reported entries is not zero.");

	err_trailer_a: assert property (
		rspValid && rspLast && st_reg.kind == ertr_pkg::ERTR_K_ERR
		|-> rspData == `ERTR_ID_ERR_LIST && outIdx == `ERTR_RSP_LAST_WORD)
		else $error("Error response trailer wrong.");

	month_range_a: assert property (
		rspValid && st_reg.kind == ertr_pkg::ERTR_K_TIME && outIdx == `ERTR_W_MONTH
		|-> rspData >= 16'h0001 && rspData <= 16'h000C)
		else $error("Month out of range.");

	time_trailer_a: assert property (
		rspValid && rspLast && st_reg.kind == ertr_pkg::ERTR_K_TIME
		|-> rspData == `ERTR_ID_TIME)
		else $error("Time response trailer wrong.");

	no_invalid_rsp_a: assert property (
		reqDone && !reqOk |=> !rspValid [*3])
		else $error("Invalid request was answered.");

	// Timing of the exchange and the ranges of the time words; the handshake
	// checks catch a word lost or replaced while the controller stalls.
	answer_start_a: assert property (
		reqDone && reqOk |=> ##1 (rspValid && rspFirst))
		else $error("Valid request not answered on time.");

	day_range_a: assert property (
		rspValid && st_reg.kind == ertr_pkg::ERTR_K_TIME && outIdx == `ERTR_W_DAY
		|-> rspData >= 16'h0001 && rspData <= 16'h001F)
		else $error("Day out of range.");

	hour_range_a: assert property (
		rspValid && st_reg.kind == ertr_pkg::ERTR_K_TIME && outIdx == `ERTR_W_HOUR
		|-> rspData <= 16'h0017)
		else $error("Hour out of range.");

	minute_range_a: assert property (
		rspValid && st_reg.kind == ertr_pkg::ERTR_K_TIME && outIdx == `ERTR_W_MINUTE
		|-> rspData <= 16'h003B)
		else $error("Minute out of range.");

	second_range_a: assert property (
		rspValid && st_reg.kind == ertr_pkg::ERTR_K_TIME && outIdx == `ERTR_W_SECOND
		|-> rspData <= 16'h003B)
		else $error("Second out of range.");

	msec_range_a: assert property (
		rspValid && st_reg.kind == ertr_pkg::ERTR_K_TIME && outIdx == `ERTR_W_MSEC
		|-> rspData <= 16'h03E7)
		else $error("Millisecond out of range.");

	time_spare_a: assert property (
		rspValid && st_reg.kind == ertr_pkg::ERTR_K_TIME
		&& outIdx > `ERTR_W_MSEC && !rspLast
		|-> rspData == 16'h0000)
		else $error("Spare time word is not zero.");

	busy_not_ready_a: assert property (
		rspValid |-> !reqReady)
		else $error("Request side open while a response is out.");

	word_hold_a: assert property (
		rspValid && !rspReady |=> rspValid && $stable(rspData))
		else $error("Response word changed before it was taken.");

	block_release_a: assert property (
		rspValid && rspLast && rspReady |=> reqReady && !rspValid)
		else $error("Request side not reopened after a response.");

endmodule : ertr_block_xchg

// *** ertr_plc_model.sv ***
/*
 * Controller partner model: sends request blocks word by word and takes
 * response words, either at once or with random stalls.
 * Assumes the block's clock and inputs changed 1 ns after the rising edge.
 */
`timescale 1ns/1ps

module ertr_plc_model (
	input  wire logic        clk,
	input  wire logic        reqReady,
	input  wire logic        rspValid,
	input  wire logic        rspFirst,
	input  wire logic        rspLast,
	input  wire logic [15:0] rspData,
	input  wire logic        slowMode,
	input  wire logic        readyBit,
	output      logic        reqValid,
	output      logic        reqFirst,
	output      logic [15:0] reqData,
	output      logic        rspReady
);
	logic [15:0] rspMem [0:249];
	int          rspCnt = 0;
	int          firstAt = -1;
	int          lastAt = -1;
	int          busyOverlap = 0;
	realtime     doneTime = 0;

	// Idle request lines at time zero.
	initial begin
		reqValid = 1'b0;
		reqFirst = 1'b0;
		reqData = 16'h0000;
	end

	// Each word is held until an edge samples ready; spare words change every word.
	task automatic send_block(input logic [15:0] code, input logic [15:0] cnt,
			input logic [15:0] start, input int len);
		int i;
		i = 0;
		while (i < len) begin
			reqValid = 1'b1;
			reqFirst = (i == 0);
			reqData = (i == 0) ? code : (i == 1) ? cnt : (i == 2) ? start : 16'hA5C3 ^ 16'(i);
			@(posedge clk);
			if (reqReady === 1'b1) begin
				if (i == 247)
					doneTime = $realtime;
				i++;
			end
			#1;
		end
		reqValid = 1'b0;
		reqFirst = 1'b0;
		reqData = ~reqData;
		@(posedge clk); // One idle edge keeps a following block out of this time step.
		#1;
	endtask : send_block

	// Store taken words; only the first 250 words of a response are kept.
	always @(posedge clk) begin
		if (rspValid === 1'b1 && rspReady === 1'b1) begin
			if (rspCnt < 250)
				rspMem[rspCnt] <= rspData;
			if (rspFirst === 1'b1)
				firstAt <= rspCnt;
			if (rspLast === 1'b1)
				lastAt <= rspCnt;
			rspCnt <= rspCnt + 1;
		end
		if (rspValid === 1'b1 && reqReady === 1'b1)
			busyOverlap <= busyOverlap + 1;
		rspReady <= #1 slowMode ? readyBit : 1'b1;
	end
endmodule : ertr_plc_model

// *** ertr_block_xchg_bench.sv ***
/*
 * Self-checking bench for the error-list and time read-out exchange.
 * Assumes the design files and the controller model are compiled first.
 */
`timescale 1ns/1ps
`include "ertr_defines.svh"

module ertr_block_xchg_bench;
	localparam int unsigned CPM = 10;
	logic                 clk, rst_n, reqValid, reqFirst, reqReady, rspReady;
	logic                 rspValid, rspFirst, rspLast, errWrEn, timeLoadEn;
	logic                 slowMode, readyBit;
	logic [15:0]          reqData, rspData, errWrCode, nextBlockId;
	logic [9:0]           errWrIndex;
	ertr_pkg::ertr_time_t timeLoadValue;
	logic [15:0]          tab [0:999];
	logic [31:0]          seed = 32'h000058A4;
	logic [31:0]          rdySeed = 32'h000058A4;
	int                   n_mismatch = 0;
	int                   n_checks = 0;
	int                   i, n, d;
	realtime              tLoad;
	int                   cc [9] = '{16'h0001, 16'h00C8, 16'h00C8, 16'h00C8, 16'h0005,
		16'h0001, 16'h0000, 16'h0000, 16'h0000};
	int                   ss [9] = '{16'h0000, 16'h0000, 16'h0320, 16'h03E7, 16'h03E3,
		16'h03E7, 16'h0000, 16'h0000, 16'h0000};

	ertr_block_xchg #(.CYCLES_PER_MS(CPM)) dut (.clk(clk), .rst_n(rst_n),
		.reqValid(reqValid), .reqFirst(reqFirst), .reqData(reqData), .reqReady(reqReady),
		.rspReady(rspReady), .rspValid(rspValid), .rspFirst(rspFirst), .rspLast(rspLast),
		.rspData(rspData), .errWrEn(errWrEn), .errWrIndex(errWrIndex),
		.errWrCode(errWrCode), .nextBlockId(nextBlockId), .timeLoadEn(timeLoadEn),
		.timeLoadValue(timeLoadValue));

	ertr_plc_model model (.clk(clk), .reqReady(reqReady), .rspValid(rspValid),
		.rspFirst(rspFirst), .rspLast(rspLast), .rspData(rspData), .slowMode(slowMode),
		.readyBit(readyBit), .reqValid(reqValid), .reqFirst(reqFirst),
		.reqData(reqData), .rspReady(rspReady));

	// Galois shift register; a fixed start keeps every run the same.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ({1'b0, s[31:1]} ^ 32'h80200003) : {1'b0, s[31:1]};
	endfunction : lfsr

	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		n_checks++;
		if (seen !== expd) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
		end
	endtask : check

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// Bounded wait for a whole response, then the request side must reopen.
	task automatic wait_rsp();
		int w;
		w = 0;
		while (model.rspCnt < 250 && w < 3000) begin
			@(posedge clk);
			w++;
		end
		repeat (3) @(posedge clk);
		#1;
		check(model.rspCnt, 250);
		check(reqReady, 1'b1);
		check(model.busyOverlap, 0);
		check(model.firstAt, 0);
		check(model.lastAt, 249);
		model.firstAt = -1;
		model.lastAt = -1;
	endtask : wait_rsp

	// Error-table request; the expected count is cut at the table end.
	task automatic run_err(input int cnt, input int start);
		int k, m;
		seed = lfsr(seed);
		nextBlockId = seed[15:0];
		model.rspCnt = 0;
		model.send_block(`ERTR_ID_ERR_LIST, 16'(cnt), 16'(start), 248);
		wait_rsp();
		m = (start + cnt > 1000) ? 1000 - start : cnt;
		check(model.rspMem[0], 16'h0000);
		check(model.rspMem[1], nextBlockId);
		check(model.rspMem[2], m);
		check(model.rspMem[3], start);
		for (k = 4; k < 249; k++)
			check(model.rspMem[k], (k < 4 + m) ? tab[start + k - 4] : 16'h0000);
		check(model.rspMem[249], `ERTR_ID_ERR_LIST);
	endtask : run_err

	// A refused block must leave no response behind and ready high.
	task automatic run_bad(input logic [15:0] code, input int cnt, input int start);
		model.rspCnt = 0;
		model.send_block(code, 16'(cnt), 16'(start), 248);
		repeat (20) @(posedge clk);
		#1;
		check(model.rspCnt, 0);
		check(reqReady, 1'b1);
	endtask : run_bad

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Random stall pattern for the response side.
	always @(posedge clk) begin
		rdySeed <= lfsr(rdySeed);
		readyBit <= #1 rdySeed[3] | rdySeed[7];
	end

	// Cut a hang short well beyond the expected run length.
	initial begin
		#6000000;
		n_mismatch++;
		complete_run();
	end

	// Main sequence.
	initial begin
		rst_n = 1'b0;
		errWrEn = 1'b0;
		errWrIndex = 10'h000;
		errWrCode = 16'h0000;
		nextBlockId = 16'h0000;
		timeLoadEn = 1'b0;
		timeLoadValue = '0;
		slowMode = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		check(reqReady, 1'b1);
		check(rspValid, 1'b0);
		// Two passes over the table, so only the last code of each entry counts.
		for (i = 0; i < 2000; i++) begin
			seed = lfsr(seed);
			errWrEn = 1'b1;
			errWrIndex = 10'(i % 1000);
			errWrCode = seed[15:0];
			tab[i % 1000] = seed[15:0];
			@(posedge clk);
			#1;
		end
		errWrEn = 1'b0;
		for (i = 0; i < 9; i++) begin
			seed = lfsr(seed);
			slowMode = seed[0];
			if (i < 6)
				run_err(cc[i], ss[i]);
			else
				run_err(1 + seed[15:8] % 200, seed[31:16] % 1000);
		end
		slowMode = 1'b0;
		run_bad(`ERTR_ID_ERR_LIST, 0, 0);
		run_bad(`ERTR_ID_ERR_LIST, 201, 0);
		run_bad(`ERTR_ID_ERR_LIST, 1, 1000);
		run_bad(16'h26F3, 1, 0);
		// Refused block, then a torn block restarted by a new first word.
		model.send_block(`ERTR_ID_ERR_LIST, 16'h00C9, 16'h0000, 248);
		model.send_block(`ERTR_ID_ERR_LIST, 16'h0003, 16'h000A, 2);
		slowMode = 1'b1;
		run_err(7, 993);
		// Load a time just before New Year so the snapshot carries every field.
		timeLoadValue = '{16'h07E7, 4'hC, 5'h1F, 5'h17, 6'h3B, 6'h3B, 10'h3D4};
		timeLoadEn = 1'b1;
		@(posedge clk);
		tLoad = $realtime;
		#1 timeLoadEn = 1'b0;
		seed = lfsr(seed);
		nextBlockId = seed[15:0];
		model.rspCnt = 0;
		model.send_block(`ERTR_ID_TIME, 16'h1234, 16'h4321, 248);
		wait_rsp();
		n = int'((model.doneTime - tLoad) / 100.0) / CPM;
		check(model.rspMem[0], 16'h0000);
		check(model.rspMem[1], nextBlockId);
		check(model.rspMem[2], 16'h07E8);
		check(model.rspMem[3], 16'h0001);
		check(model.rspMem[4], 16'h0001);
		for (i = 5; i < 8; i++)
			check(model.rspMem[i], 16'h0000);
		d = int'(model.rspMem[8]) - (980 + n - 1000);
		check(d >= -1 && d <= 1, 1'b1);
		for (i = 9; i < 249; i++)
			check(model.rspMem[i], 16'h0000);
		check(model.rspMem[249], `ERTR_ID_TIME);
		complete_run();
	end
endmodule : ertr_block_xchg_bench
